// File: core/adc_out_cfg.svh
// Constants for the dual converter output stage.
`ifndef ADC_OUT_CFG_SVH
`define ADC_OUT_CFG_SVH
`define ADC_WIDTH 12
`define ADC_LATENCY 6
`define ADC_CODE_MAX 12'hFFF
`define ADC_CODE_MID 12'h800
`define ADC_CODE_MIN 12'h000
`define ADC_CODE_HALF_POS 12'hC00
`define ADC_CODE_HALF_NEG 12'h400
`define ADC_PIPE_RESET 13'h0000
`define ADC_FLOAT_RESET 2'h0
`define ADC_DRIVE_RESET 2'h3
`define ADC_WARM_RESET 4'h0
`endif

// File: core/adc_out_pkg.sv
// Types for the dual converter output stage.
`include "adc_out_cfg.svh"
package adc_out_pkg;
    typedef logic [`ADC_WIDTH-1:0] offset_binary_code_t;
endpackage : adc_out_pkg

// File: core/dual_adc_output_interface.sv
// Digital output side of a dual-channel converter: pipeline, flag and float control.
`include "adc_out_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module dual_adc_output_interface
    import adc_out_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [`ADC_WIDTH-1:0] sample_a_in,
    input wire logic [`ADC_WIDTH-1:0] sample_b_in,
    input wire logic range_exceeded_a_in,
    input wire logic range_exceeded_b_in,
    input wire logic float_a_in,
    input wire logic float_b_in,
    output logic [`ADC_WIDTH-1:0] offset_binary_code_a_out,
    output logic [`ADC_WIDTH-1:0] offset_binary_code_b_out,
    output logic range_exceeded_flag_a_out,
    output logic range_exceeded_flag_b_out,
    output logic drive_en_a_out,
    output logic drive_en_b_out
);
    // ------------------------------------------------------------------
    // Conversion pipeline
    // ------------------------------------------------------------------
    // Codes arrive already in offset binary from the quantiser, so no recoding is done.
    // Each channel has its own pipeline; the flag rides as the top bit of each word.
    // Carrying the flag inside the same word as its code means the two can never
    // drift apart, whatever latency is chosen.
    // Both pipelines load on the same edge, so the channels stay aligned.
    localparam int W = `ADC_WIDTH + 1;
    logic [W-1:0] pipe_a_q [`ADC_LATENCY];
    logic [W-1:0] pipe_b_q [`ADC_LATENCY];
    logic [1:0] float_s1_q;
    logic [1:0] drive_q;
    logic [3:0] warm_q;
    logic [3:0] warm_d;
    wire logic [W-1:0] in_a = {range_exceeded_a_in, sample_a_in};
    wire logic [W-1:0] in_b = {range_exceeded_b_in, sample_b_in};

    // The first stage takes the fresh samples of both channels.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            pipe_a_q[0] <= `ADC_PIPE_RESET;
            pipe_b_q[0] <= `ADC_PIPE_RESET;
        end else begin
            pipe_a_q[0] <= in_a;
            pipe_b_q[0] <= in_b;
        end
    end

    // Every later stage just hands its word on; no stage ever holds or skips,
    // so the delay is fixed and exactly the configured number of edges.
    genvar g;
    generate
        for (g = 1; g < `ADC_LATENCY; g++) begin : g_stage
            always_ff @(posedge clock_in) begin
                if (!resetn_in) begin
                    pipe_a_q[g] <= `ADC_PIPE_RESET;
                    pipe_b_q[g] <= `ADC_PIPE_RESET;
                end else begin
                    pipe_a_q[g] <= pipe_a_q[g-1];
                    pipe_b_q[g] <= pipe_b_q[g-1];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Float control is a pin, so it passes two flip-flops before use.
    // The second flop holds the enable itself, already inverted, so the
    // enable outputs come straight from a register with no gate after it.
    // Reset leaves both channels driving, as the pin's pull-down would.
    // The control is meant as a static test setting; a change takes two
    // edges to reach the enable, and no attempt is made to hide that.
    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            float_s1_q <= `ADC_FLOAT_RESET;
            drive_q <= `ADC_DRIVE_RESET;
        end else begin
            float_s1_q <= {float_b_in, float_a_in};
            drive_q <= ~float_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // Pipeline fill tracking
    // ------------------------------------------------------------------
    // Counts edges since reset left, saturating at the latency. Only the
    // checks read it: once it is full, every output word belongs to a
    // sample taken after reset, and a reset in mid-run starts it again.
    wire logic warm_full = (warm_q == 4'(`ADC_LATENCY));
    assign warm_d = warm_full ? warm_q : warm_q + 4'h1;

    always_ff @(posedge clock_in) begin
        if (!resetn_in) begin
            warm_q <= `ADC_WARM_RESET;
        end else begin
            warm_q <= warm_d;
        end
    end

    // ------------------------------------------------------------------
    // Output taps
    // ------------------------------------------------------------------
    // The last stage feeds the pins directly; splitting it is wiring only.
    wire logic [W-1:0] last_a = pipe_a_q[`ADC_LATENCY-1];
    wire logic [W-1:0] last_b = pipe_b_q[`ADC_LATENCY-1];
    assign offset_binary_code_a_out = last_a[`ADC_WIDTH-1:0];
    assign offset_binary_code_b_out = last_b[`ADC_WIDTH-1:0];
    assign range_exceeded_flag_a_out = last_a[W-1];
    assign range_exceeded_flag_b_out = last_b[W-1];
    assign drive_en_a_out = drive_q[0];
    assign drive_en_b_out = drive_q[1];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    // The latency checks wait for a full pipeline, so a reset inside the
    // look-back window cannot make them compare against a cleared stage.
    a_data_a_latency: assert property (warm_full |->
        offset_binary_code_a_out == $past(sample_a_in, `ADC_LATENCY))
        else $error("Channel A data latency wrong.");
    a_data_b_latency: assert property (warm_full |->
        offset_binary_code_b_out == $past(sample_b_in, `ADC_LATENCY))
        else $error("Channel B data latency wrong.");
    a_flag_a_aligned: assert property (warm_full |->
        range_exceeded_flag_a_out == $past(range_exceeded_a_in, `ADC_LATENCY))
        else $error("Channel A flag not aligned with data.");
    a_flag_b_aligned: assert property (warm_full |->
        range_exceeded_flag_b_out == $past(range_exceeded_b_in, `ADC_LATENCY))
        else $error("Channel B flag not aligned with data.");

    // While the pipeline fills, only the cleared reset words may appear;
    // a word arriving early would show up here.
    a_fill_quiet_a: assert property (!warm_full |->
        offset_binary_code_a_out == `ADC_CODE_MIN && !range_exceeded_flag_a_out)
        else $error("Channel A output before the pipeline filled.");
    a_fill_quiet_b: assert property (!warm_full |->
        offset_binary_code_b_out == `ADC_CODE_MIN && !range_exceeded_flag_b_out)
        else $error("Channel B output before the pipeline filled.");

    a_same_edge: assert property ((sample_a_in == sample_b_in) ##0
        $past(resetn_in) |=> pipe_a_q[0][`ADC_WIDTH-1:0] == pipe_b_q[0][`ADC_WIDTH-1:0])
        else $error("Channels not sampled on the same edge.");
    a_float_a_drive: assert property (float_a_in ##1 float_a_in |=> !drive_en_a_out)
        else $error("Channel A did not float.");
    a_float_b_drive: assert property (!float_b_in ##1 !float_b_in |=> drive_en_b_out)
        else $error("Channel B did not drive.");
    a_float_b_off: assert property (float_b_in ##1 float_b_in |=> !drive_en_b_out)
        else $error("Channel B did not float.");
    a_float_a_on: assert property (!float_a_in ##1 !float_a_in |=> drive_en_a_out)
        else $error("Channel A did not drive.");
    a_code_passthru: assert property (warm_full &&
        $past(sample_a_in, `ADC_LATENCY) == `ADC_CODE_MID |->
        offset_binary_code_a_out == `ADC_CODE_MID)
        else $error("Mid-scale code altered.");

    // Reset must leave words cleared and both channels driving; these two
    // look through reset on purpose, so they carry their own disable.
    a_reset_a_clear: assert property (disable iff (1'b0) !resetn_in |=>
        offset_binary_code_a_out == `ADC_CODE_MIN && drive_en_a_out)
        else $error("Channel A not cleared by reset.");
    a_reset_b_clear: assert property (disable iff (1'b0) !resetn_in |=>
        offset_binary_code_b_out == `ADC_CODE_MIN && drive_en_b_out)
        else $error("Channel B not cleared by reset.");

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------
    c_overrange: cover property (range_exceeded_flag_a_out);
    c_float_a: cover property (!drive_en_a_out);
    c_full_scale: cover property (offset_binary_code_b_out == `ADC_CODE_MAX);
    c_float_b: cover property (!drive_en_b_out);
    c_mid_scale: cover property (warm_full && offset_binary_code_a_out == `ADC_CODE_MID);
endmodule : dual_adc_output_interface
`default_nettype wire

// File: dv/dual_adc_output_interface_tb.sv
// Self-checking bench for the dual converter output stage.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module dual_adc_output_interface_tb;
    import adc_out_pkg::*;
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    offset_binary_code_t sa = 12'h000, sb = 12'h000, ya, yb, twos_a, twos_b;
    offset_binary_code_t pa = 12'h000, pb = 12'h000;
    logic ra = 1'b0, rb = 1'b0, fa = 1'b0, fb = 1'b0, oa, ob, ea, eb;
    logic [25:0] dq[$];
    logic [1:0] fq[$];
    logic [25:0] x;
    logic [1:0] f;
    int fails = 0, samples_checked = 0, seed = 32'hD110;
    offset_binary_code_t corner[5] = '{`ADC_CODE_MAX, `ADC_CODE_MID, `ADC_CODE_MIN,
        `ADC_CODE_HALF_POS, `ADC_CODE_HALF_NEG};
    dual_adc_output_interface dut (.clock_in(clock_in), .resetn_in(resetn_in),
        .sample_a_in(sa), .sample_b_in(sb), .range_exceeded_a_in(ra),
        .range_exceeded_b_in(rb), .float_a_in(fa), .float_b_in(fb),
        .offset_binary_code_a_out(ya), .offset_binary_code_b_out(yb),
        .range_exceeded_flag_a_out(oa), .range_exceeded_flag_b_out(ob),
        .drive_en_a_out(ea), .drive_en_b_out(eb));
    sample_capture cap_a (.clock_in(clock_in), .word_in(ya), .drive_en_in(ea),
        .twos_out(twos_a));
    sample_capture cap_b (.clock_in(clock_in), .word_in(yb), .drive_en_in(eb),
        .twos_out(twos_b));
    initial begin
        forever #10 clock_in = ~clock_in;
    end
    // The receiver's view of a word in two's complement: only the top bit flips.
    function automatic offset_binary_code_t to_twos(input offset_binary_code_t c);
        return {~c[11], c[10:0]};
    endfunction : to_twos
    task print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge clock_in);
        #2 resetn_in = 1'b1;
        // Reset leaves zeros in every stage and the float sync cleared.
        repeat (6) dq.push_back(26'h0);
        repeat (2) fq.push_back(2'h0);
        for (int i = 0; i < 400; i++) begin
            x = dq.pop_front();
            f = fq.pop_front();
            `CHK({oa, ya, ob, yb}, x)
            `CHK({ea, eb}, ~f)
            `CHK(twos_a, to_twos(pa))
            `CHK(twos_b, to_twos(pb))
            // A floated word reads back as the inverse of the last one seen.
            pa = f[1] ? ~pa : x[24:13];
            pb = f[0] ? ~pb : x[11:0];
            sa = (i < 5) ? corner[i] : 12'($random(seed));
            sb = (i < 5) ? corner[4-i] : 12'($random(seed));
            ra = (($random(seed) & 7) == 0);
            rb = (($random(seed) & 7) == 0);
            // Float is held as a static test setting for a stretch, never toggled per sample.
            fa = (i >= 100 && i < 110);
            fb = (i >= 200 && i < 210);
            dq.push_back({ra, sa, rb, sb});
            fq.push_back({fa, fb});
            @(posedge clock_in);
            #2;
        end
        $display("test stream and float done");
        print_verdict();
    end
endmodule : dual_adc_output_interface_tb
`default_nettype wire

// File: dv/sample_capture.sv
// Downstream capture model for one converter output word.
`timescale 1ns/1ns
`default_nettype none
module sample_capture (
    input wire logic clock_in,
    input wire logic [11:0] word_in,
    input wire logic drive_en_in,
    output logic [11:0] twos_out
);
    logic [11:0] last_q;
    // A floated bus shows the inverse of its last value, so no stale copy can pass.
    wire [11:0] pin_w = drive_en_in ? word_in : ~last_q;
    always_ff @(posedge clock_in) begin
        last_q <= pin_w;
        twos_out <= {~pin_w[11], pin_w[10:0]};
    end
endmodule : sample_capture
`default_nettype wire
